// ### hw/acs_pkg.sv
package acs_pkg;

  // Register indices; the byte address of each is four times its index.
  localparam logic [7:0] IDX_PORT_LEVELS = 8'h05;
  localparam logic [7:0] IDX_IRQ_FLAGS = 8'h0c;
  localparam logic [7:0] IDX_RESULT = 8'h1e;
  localparam logic [7:0] IDX_CONTROL = 8'h1f;
  localparam logic [7:0] IDX_PIN_DIR = 8'h85;
  localparam logic [7:0] IDX_IRQ_ENABLES = 8'h8c;
  localparam logic [7:0] IDX_PIN_CONFIG = 8'h9f;
  localparam int ADDR_W = 12;

  // Field positions.
  localparam int DONE_FLAG_BIT = 6;
  localparam int DONE_IRQ_EN_BIT = 6;
  localparam int PIN_COUNT = 4;

  // Reset values.
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [2:0] PIN_CONFIG_RESET = 3'h0;
  localparam logic [3:0] PIN_DIR_RESET = 4'hf;

  // Compare unit mode that turns its match into a conversion trigger.
  localparam logic [3:0] TRIGGER_MODE = 4'hb;

  // Timing: clock period and the bit conversion periods.
  localparam int CLK_PERIOD_NS = 4;
  localparam int TAD_OSC_FAST = 2;
  localparam int TAD_OSC_MID = 8;
  localparam int TAD_OSC_SLOW = 32;
  localparam int RC_TAD_NS = 4000;
  localparam int RC_TAD_CYCLES = RC_TAD_NS / CLK_PERIOD_NS;
  localparam int CONV_HALF_TADS = 19;
  localparam int HALF_W = 10;

  // Control register layout, bit 7 down to bit 0.
  typedef struct packed {
    logic [1:0] conv_clock_select;
    logic [2:0] channel_select;
    logic go;
    logic reserved;
    logic converter_on;
  } acs_control_t;

  // Signals towards the analog front end.
  typedef struct packed {
    logic hold_connect;
    logic [1:0] channel;
    logic vref_from_pin;
    logic [3:0] analog_mask;
    logic [7:0] dac_code;
  } acs_analog_t;

endpackage

// ### hw/acs_top.sv
`timescale 1ns/1ns
// Overview of operation
// R1: Port field picks analog pins and reference; 11x makes all digital.
// R2: Port configuration bits 7..3 always read as zero.
// R3: At completion load result, clear go, set done flag; a control write with go and converter on in that cycle leaves go set.
// R4: Result register is never reset and powers up unknown.
// R5: Software waits two bit periods after a conversion before acquiring.
// R6: A conversion lasts nine and a half bit periods.
// R7: Clock select 00,01,10 gives 2,8,32 clocks; 11 uses RC clock.
// R8: Software picks a clock giving at least 1.6 us per bit.
// R9: RC clock gives a bit period of typically 4 us.
// R10: RC clock is meant for sleep only above 1 MHz.
// R11: Hold capacitor disconnects from the pin when conversion starts.
// R12: Software lets acquisition time pass after a channel change.
// R13: Software sets analog pins as inputs.
// R14: A pin driven as output has its driven level converted.
// R15: Channel and direction settings never block a conversion.
// R16: Port read returns zero for every analog configured pin.
// R17: Software does not set go in the write that turns converter on.
// R18: Trigger in mode 1011 with converter on sets go and clears timer one.
// R19: Converter off ignores trigger; timer one still clears.
// R20: Software configures, enables interrupts, waits, starts, polls, reads.
// R21: Channel codes 000..011 pick inputs 0..3; 1xx reserved.
// R22: Converter off bit shuts the module down; a trigger in the same cycle as the off write still starts a conversion.
// R23: Reset clears control registers and aborts any conversion.
// R24: Reserved control bit 1 is kept zero by software.
// R25: Go written while converter off starts nothing and stays clear.
module acs_top
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [acs_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] compare_mode_field,
  input wire logic special_event_trigger,
  output logic timer_one_clear,
  input wire logic [3:0] port_pins,
  input wire logic comparator_high,
  output acs_pkg::acs_analog_t analog_out,
  output logic [3:0] pin_direction_bits,
  output logic conv_done_irq
);
  import acs_pkg::*;

  acs_control_t converter_control;
  acs_control_t wr_ctl;
  logic [2:0] port_config_field;
  logic [3:0] pin_direction_reg, pins_meta, pins_sync;
  logic conv_done_flag, conv_done_irq_enable;
  logic [7:0] conversion_result, trial, probe, next_trial, index_byte;
  logic comp_meta, comp_sync, converting, half_tick, conv_finish;
  logic [HALF_W-1:0] half_count, half_limit;
  logic [4:0] half_index, pin_use;
  logic bus_write, bus_setup, addr_ok, ctl_write;
  logic sw_go, trigger_go, start_conv, abort_conv;

  // Port configuration decode: bits 3..0 are analog inputs, bit 4 selects
  // the reference pin.
  function automatic logic [4:0] port_use(input logic [2:0] code);
    logic [4:0] use_bits;
    use_bits = 5'h00;
    case (code)
      3'h0, 3'h2: use_bits = 5'h0f; // [R1]
      3'h1, 3'h3: use_bits = 5'h17; // [R1]
      3'h4: use_bits = 5'h0b; // [R1]
      3'h5: use_bits = 5'h13; // [R1]
      default: use_bits = 5'h00; // [R1]
    endcase
    return use_bits;
  endfunction

  // Checks that an index names a mapped register.
  function automatic logic index_mapped(input logic [7:0] idx);
    return idx == IDX_PORT_LEVELS || idx == IDX_IRQ_FLAGS ||
           idx == IDX_RESULT || idx == IDX_CONTROL ||
           idx == IDX_PIN_DIR || idx == IDX_IRQ_ENABLES ||
           idx == IDX_PIN_CONFIG;
  endfunction

  // Bus qualifiers; the slave answers in the first access cycle with clk_en high.
  // A byte address names word index addr/4; misaligned ones are refused.
  always_comb
  begin
    index_byte = paddr[9:2];
    addr_ok = paddr[1:0] == 2'h0 && paddr[ADDR_W-1:10] == 2'h0 &&
              index_mapped(index_byte);
    bus_setup = psel && !penable && clk_en;
    bus_write = psel && penable && pwrite && addr_ok && clk_en;
    ctl_write = bus_write && index_byte == IDX_CONTROL;
    pready = clk_en;
  end

  assign pin_use = port_use(port_config_field);
  assign wr_ctl = acs_control_t'(pwdata[7:0]);

  // Pin levels and comparator come from outside the clock domain.
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      pins_meta <= 4'h0;
      pins_sync <= 4'h0;
      comp_meta <= 1'b0;
      comp_sync <= 1'b0;
    end
    else if (clk_en)
    begin
      pins_meta <= port_pins;
      pins_sync <= pins_meta;
      comp_meta <= comparator_high;
      comp_sync <= comp_meta;
    end
  end

  // Start and abort conditions for a conversion.
  always_comb
  begin
    sw_go = ctl_write && wr_ctl.go && wr_ctl.converter_on &&
            converter_control.converter_on; // [R25] [R17]
    trigger_go = special_event_trigger &&
                 compare_mode_field == TRIGGER_MODE &&
                 converter_control.converter_on; // [R18] [R19]
    start_conv = !converting && (sw_go || trigger_go); // [R15]
    abort_conv = converting && ctl_write &&
                 (!wr_ctl.converter_on || !wr_ctl.go); // [R22]
  end

  // Half bit period length picked by the clock select field.
  always_comb
  begin
    case (converter_control.conv_clock_select) // [R7]
      2'h0: half_limit = HALF_W'(TAD_OSC_FAST / 2);
      2'h1: half_limit = HALF_W'(TAD_OSC_MID / 2);
      2'h2: half_limit = HALF_W'(TAD_OSC_SLOW / 2);
      default: half_limit = HALF_W'(RC_TAD_CYCLES / 2); // [R9]
    endcase
  end

  assign half_tick = converting && half_count == half_limit - HALF_W'(1);
  assign conv_finish = half_tick &&
                       half_index == 5'(CONV_HALF_TADS - 1); // [R6]

  // Successive approximation step: keep or drop the probed bit.
  assign next_trial = (comp_sync ? trial : trial & ~probe) | (probe >> 1);

  // Half bit period timer and step counter.
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      converting <= 1'b0;
      half_count <= '0;
      half_index <= 5'h00;
    end
    else if (clk_en)
    begin
      if (start_conv)
      begin
        converting <= 1'b1;
        half_count <= '0;
        half_index <= 5'h00;
      end
      else if (abort_conv || conv_finish)
      begin
        converting <= 1'b0;
      end
      else if (half_tick)
      begin
        half_count <= '0;
        half_index <= half_index + 5'h01;
      end
      else if (converting)
      begin
        half_count <= half_count + HALF_W'(1);
      end
    end
  end

  // Bit decisions at odd half periods 3 through 17, MSB first.
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      trial <= 8'h00;
      probe <= 8'h00;
    end
    else if (clk_en)
    begin
      if (start_conv)
      begin
        trial <= 8'h80;
        probe <= 8'h80;
      end
      else if (half_tick && half_index[0] && probe != 8'h00 &&
               half_index >= 5'h02)
      begin
        trial <= next_trial;
        probe <= probe >> 1;
      end
    end
  end

  // Front end drive; the hold switch opens for the whole conversion.
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      analog_out <= '0;
    end
    else if (clk_en)
    begin
      analog_out.hold_connect <= converter_control.converter_on &&
                                 !(converting || start_conv); // [R11]
      analog_out.channel <= converter_control.channel_select[1:0]; // [R21]
      analog_out.vref_from_pin <= pin_use[4]; // [R1]
      analog_out.analog_mask <= pin_use[3:0]; // [R1]
      analog_out.dac_code <= start_conv ? 8'h80 : trial;
    end
  end

  // The sampled pin is taken whatever its direction, so an output pin
  // presents its own driven level to the hold capacitor.
  assign pin_direction_bits = pin_direction_reg; // [R14]

  // Control register: go set by software or trigger, cleared at the end; a control write in that cycle wins.
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      converter_control <= CONTROL_RESET; // [R23]
    end
    else if (clk_en)
    begin
      if (ctl_write)
      begin
        converter_control <= wr_ctl;
        converter_control.reserved <= 1'b0; // [R24]
        converter_control.go <= start_conv ||
                                (converting && !abort_conv); // [R25]
        if (!wr_ctl.converter_on)
        begin
          converter_control.go <= 1'b0; // [R22]
        end
      end
      else if (start_conv)
      begin
        converter_control.go <= 1'b1; // [R18]
      end
      else if (conv_finish)
      begin
        converter_control.go <= 1'b0; // [R3]
      end
    end
  end

  // Port configuration, pin direction and interrupt enable registers.
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      port_config_field <= PIN_CONFIG_RESET;
      pin_direction_reg <= PIN_DIR_RESET;
      conv_done_irq_enable <= 1'b0;
    end
    else if (clk_en && bus_write)
    begin
      case (index_byte)
        IDX_PIN_CONFIG: port_config_field <= pwdata[2:0];
        IDX_PIN_DIR: pin_direction_reg <= pwdata[3:0];
        IDX_IRQ_ENABLES: conv_done_irq_enable <= pwdata[DONE_IRQ_EN_BIT];
        default: ;
      endcase
    end
  end

  // Done flag: a completion in the same cycle as a clear keeps it set.
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      conv_done_flag <= 1'b0;
    end
    else if (clk_en)
    begin
      if (conv_finish)
      begin
        conv_done_flag <= 1'b1; // [R3]
      end
      else if (bus_write && index_byte == IDX_IRQ_FLAGS)
      begin
        conv_done_flag <= pwdata[DONE_FLAG_BIT];
      end
    end
  end

  // Result register has no reset; hardware load wins over a write.
  always_ff @(posedge clk)
  begin
    if (clk_en)
    begin
      if (conv_finish)
      begin
        conversion_result <= next_trial; // [R3] [R4]
      end
      else if (bus_write && index_byte == IDX_RESULT)
      begin
        conversion_result <= pwdata[7:0];
      end
    end
  end

  // Timer one clear pulse follows every trigger in trigger mode.
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      timer_one_clear <= 1'b0;
    end
    else if (clk_en)
    begin
      timer_one_clear <= special_event_trigger &&
                         compare_mode_field == TRIGGER_MODE; // [R18] [R19]
    end
  end

  // Done interrupt request towards the interrupt controller.
  assign conv_done_irq = conv_done_flag && conv_done_irq_enable;

  // Read data and error are captured in the setup cycle.
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (bus_setup)
    begin
      prdata <= 32'h0000_0000;
      pslverr <= !addr_ok;
      if (!pwrite)
      begin
        case (index_byte)
          IDX_PORT_LEVELS: prdata[3:0] <= pins_sync & ~pin_use[3:0] &
                                          ~{pin_use[4], 3'h0}; // [R16]
          IDX_IRQ_FLAGS: prdata[DONE_FLAG_BIT] <= conv_done_flag;
          IDX_RESULT: prdata[7:0] <= conversion_result;
          IDX_CONTROL: prdata[7:0] <= converter_control;
          IDX_PIN_DIR: prdata[3:0] <= pin_direction_reg;
          IDX_IRQ_ENABLES: prdata[DONE_IRQ_EN_BIT] <= conv_done_irq_enable;
          IDX_PIN_CONFIG: prdata[2:0] <= port_config_field; // [R2]
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule

// ### testbench/acs_analog_model.sv
`timescale 1ns/1ns
// Analog pins and sample-and-hold in front of the converter.
module acs_analog_model
(
  input wire logic clk,
  input wire acs_pkg::acs_analog_t analog_out,
  input wire logic [31:0] levels,
  output logic comparator_high,
  output logic [3:0] port_pins
);
  import acs_pkg::*;
  logic [7:0] held;

  // The hold capacitor follows the selected pin only while connected.
  always_ff @(posedge clk)
  begin
    if (analog_out.hold_connect)
      held <= levels[{analog_out.channel, 3'b000} +: 8];
  end

  // The comparator weighs the held level against the trial code.
  assign comparator_high = held >= analog_out.dac_code;
  // Digital pin levels are the top bit of each analog level.
  assign port_pins = {levels[31], levels[23], levels[15], levels[7]};
endmodule

// ### testbench/acs_top_props.sv
`timescale 1ns/1ns
// Checks the bus answers, the trigger path and reset of the block.
module acs_top_props
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic [acs_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [3:0] compare_mode_field,
  input wire logic special_event_trigger,
  input wire logic timer_one_clear,
  input wire acs_pkg::acs_analog_t analog_out,
  input wire logic [3:0] pin_direction_bits
);
  import acs_pkg::*;
  logic setup;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // A setup cycle that the block takes.
  assign setup = psel && !penable && clk_en;

  property p_ready; pready == clk_en; endproperty
  a_ready: assert property (p_ready)
    else $error("ready does not follow the clock enable");
  property p_upper; setup |=> prdata[31:8] == 24'h0; endproperty
  a_upper: assert property (p_upper)
    else $error("upper read data bits not zero");
  property p_cfg_read;
    setup && paddr == {2'b00, IDX_PIN_CONFIG, 2'b00} |=> prdata[7:3] == 5'h0;
  endproperty
  a_cfg_read: assert property (p_cfg_read)
    else $error("unused config bits read nonzero");
  property p_port_read;
    setup && paddr == {2'b00, IDX_PORT_LEVELS, 2'b00}
      |=> (prdata[3:0] & $past(analog_out.analog_mask)) == 4'h0;
  endproperty
  a_port_read: assert property (p_port_read)
    else $error("analog pin read as high");
  property p_unmapped; setup && paddr == 12'h000 |=> pslverr; endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped address not refused");
  property p_mapped;
    setup && paddr == {2'b00, IDX_CONTROL, 2'b00} |=> !pslverr;
  endproperty
  a_mapped: assert property (p_mapped)
    else $error("mapped address refused");
  property p_stand; psel && penable |=> $stable(prdata); endproperty
  a_stand: assert property (p_stand)
    else $error("read data changed after access");
  property p_tclr;
    special_event_trigger && compare_mode_field == TRIGGER_MODE && clk_en
      |=> timer_one_clear;
  endproperty
  a_tclr: assert property (p_tclr)
    else $error("trigger did not clear the timer");
  property p_tclr_only;
    timer_one_clear && $past(clk_en) |-> $past(special_event_trigger)
      && $past(compare_mode_field) == TRIGGER_MODE;
  endproperty
  a_tclr_only: assert property (p_tclr_only)
    else $error("timer clear without trigger");
  property p_reset;
    $rose(reset_n) |-> analog_out == '0 && !timer_one_clear
      && pin_direction_bits == PIN_DIR_RESET && prdata == 32'h0;
  endproperty
  a_reset: assert property (p_reset)
    else $error("outputs not at reset values");

  // Main scenarios reached.
  c_trig: cover property (timer_one_clear);
  c_err: cover property (pslverr);
  c_hold: cover property ($fell(analog_out.hold_connect));
endmodule

bind acs_top acs_top_props acs_top_props_inst (.clk, .reset_n, .clk_en,
  .psel, .penable, .paddr, .prdata, .pready, .pslverr, .compare_mode_field,
  .special_event_trigger, .timer_one_clear, .analog_out, .pin_direction_bits);

// ### testbench/acs_top_tb.sv
`timescale 1ns/1ns
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin \
  n_errors++; $display("mismatch t=%0t got %h exp %h", $time, got, exp); \
  end end
// Drives the block over its register bus and trigger inputs.
module acs_top_tb;
  import acs_pkg::*;
  localparam logic [11:0] A_PORT = {2'b00, IDX_PORT_LEVELS, 2'b00};
  localparam logic [11:0] A_FLG = {2'b00, IDX_IRQ_FLAGS, 2'b00};
  localparam logic [11:0] A_RES = {2'b00, IDX_RESULT, 2'b00};
  localparam logic [11:0] A_CTL = {2'b00, IDX_CONTROL, 2'b00};
  localparam logic [11:0] A_DIR = {2'b00, IDX_PIN_DIR, 2'b00};
  localparam logic [11:0] A_ENA = {2'b00, IDX_IRQ_ENABLES, 2'b00};
  localparam logic [11:0] A_CFG = {2'b00, IDX_PIN_CONFIG, 2'b00};
  logic clk, reset_n, clk_en, psel, penable, pwrite, trig, err;
  logic pready, pslverr, timer_one_clear, comparator_high, conv_done_irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, levels, rd;
  logic [3:0] mode, port_pins, pin_direction_bits;
  acs_analog_t analog_out;
  int n_errors, checked, cycles, n;

  acs_top acs_top_inst (.clk(clk), .reset_n(reset_n), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .compare_mode_field(mode), .special_event_trigger(trig),
    .timer_one_clear(timer_one_clear), .port_pins(port_pins),
    .comparator_high(comparator_high), .analog_out(analog_out),
    .pin_direction_bits(pin_direction_bits), .conv_done_irq(conv_done_irq));
  acs_analog_model acs_analog_model_inst (.clk(clk), .analog_out(analog_out),
    .levels(levels), .comparator_high(comparator_high),
    .port_pins(port_pins));

  // Free running clock.
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // A hang ends the run as a failure.
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      n_errors++;
      finish_test();
    end
  end

  task automatic finish_test();
    if (n_errors == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // One bus transfer: setup, then access until ready.
  task automatic bus(input logic [11:0] a, input logic w, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [7:0] exp);
    bus(a, 1'b0, 8'h00);
    `CHK(rd, {24'h0, exp})
  endtask

  // Counts edges from a start until the done interrupt shows.
  task automatic wait_done();
    n = 0;
    while (conv_done_irq !== 1'b1 && n < 20000)
    begin
      @(posedge clk);
      #1;
      n++;
      if (n == 1)
        `CHK(analog_out.hold_connect, 1'b0)
    end
  endtask

  task automatic pulse(input logic [3:0] m);
    @(posedge clk);
    mode <= m;
    trig <= 1'b1;
    @(posedge clk);
    trig <= 1'b0;
  endtask

  task automatic t_reset_values();
    rdchk(A_CTL, CONTROL_RESET);
    rdchk(A_CFG, 8'h00);
    rdchk(A_DIR, {4'h0, PIN_DIR_RESET});
    rdchk(A_FLG, 8'h00);
    rdchk(A_ENA, 8'h00);
    bus(12'h000, 1'b0, 8'h00);
    `CHK(err, 1'b1)
  endtask

  task automatic t_port_config();
    logic [2:0] c;
    logic [3:0] dig;
    for (int i = 0; i < 8; i++)
    begin
      c = 3'(i);
      dig = (c[2:1] == 2'b11) ? 4'hf : (c[2] ? 4'h4 : 4'h0);
      bus(A_CFG, 1'b1, {5'h1f, c});
      rdchk(A_CFG, {5'h00, c});
      rdchk(A_PORT, {4'h0, dig & port_pins});
      `CHK(analog_out.vref_from_pin, c[0] & ~(c[2] & c[1]))
    end
    bus(A_CFG, 1'b1, 8'h00);
  endtask

  task automatic t_convert(input logic [1:0] sel);
    int h;
    h = (sel == 2'd0) ? 1 : (sel == 2'd1) ? 4 : (sel == 2'd2) ? 16 : 500;
    bus(A_ENA, 1'b1, 8'h40);
    bus(A_CTL, 1'b1, {sel, 1'b0, sel, 3'b001});
    repeat (40) @(posedge clk);
    bus(A_CTL, 1'b1, {sel, 1'b0, sel, 3'b101});
    wait_done();
    `CHK(n, 19 * h)
    rdchk(A_RES, levels[{sel, 3'b000} +: 8]);
    rdchk(A_CTL, {sel, 1'b0, sel, 3'b001});
    `CHK(analog_out.hold_connect, 1'b1)
    rdchk(A_FLG, 8'h40);
    bus(A_FLG, 1'b1, 8'h00);
    #1;
    `CHK(conv_done_irq, 1'b0)
    repeat (4 * h) @(posedge clk);
  endtask

  task automatic t_go_off();
    bus(A_CTL, 1'b1, 8'h04);
    rdchk(A_CTL, 8'h00);
    repeat (30) @(posedge clk);
    `CHK(conv_done_irq, 1'b0)
  endtask

  task automatic t_reset_abort();
    bus(A_CTL, 1'b1, 8'h09);
    repeat (40) @(posedge clk);
    bus(A_CTL, 1'b1, 8'h0d);
    repeat (5) @(posedge clk);
    reset_n <= 1'b0;
    @(posedge clk);
    reset_n <= 1'b1;
    repeat (30) @(posedge clk);
    rdchk(A_CTL, 8'h00);
    rdchk(A_RES, levels[31:24]);
  endtask

  task automatic t_trigger();
    bus(A_ENA, 1'b1, 8'h40);
    pulse(TRIGGER_MODE);
    repeat (30) @(posedge clk);
    `CHK(conv_done_irq, 1'b0)
    bus(A_DIR, 1'b1, 8'h0b);
    bus(A_CTL, 1'b1, 8'h51);
    repeat (40) @(posedge clk);
    pulse(4'h3);
    repeat (30) @(posedge clk);
    `CHK(conv_done_irq, 1'b0)
    pulse(TRIGGER_MODE);
    wait_done();
    `CHK(n, 19 * 4)
    rdchk(A_RES, levels[23:16]);
  endtask

  // Main sequence.
  initial
  begin
    reset_n = 1'b0;
    clk_en = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    trig = 1'b0;
    mode = 4'h0;
    // The fastest clock breaks the minimum bit period, so channel 0, which
    // it converts, sits at full scale where every decision is the same.
    levels = 32'h3ec4a3ff;
    n_errors = 0;
    checked = 0;
    cycles = 0;
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    t_reset_values();
    t_port_config();
    // The RC run stands for the sleep case, the only one it is meant for.
    for (int i = 0; i < 4; i++)
      t_convert(2'(i));
    t_go_off();
    t_reset_abort();
    t_trigger();
    finish_test();
  end
endmodule
